// ===== charger_fault_supervisor.sv
// supervisory fault, detection and zone logic of the charger
//
// What this block does
// - voltage loop in fast charge, current loop otherwise
// - three-state detection, leaves check only if absent
// - detect states drive rail at 4.2V then 3.72V
// - rail level alternates with a 64ms period
// - comparators checked for insertion in both states
// - cycle states two and three until insertion
// - input droop lowers the effective input limit
// - sleep when input below battery plus offset and above lockout
// - sleep entry stops converter, pulses, sets its fault bit
// - sleep exit clears faults, restarts charge cycle
// - over-voltage stops converter, pulses, sets bits
// - over-voltage removal clears faults, resumes
// - over-voltage threshold selectable 6.5V to 10.5V
// - zone sets voltage and current targets
// - test mode is plain buck, no input limit
// - test mode refused when battery is present
// - safety timer paused during listed faults
`timescale 1ns/1ns
module charger_fault_supervisor (
  input wire logic pclk, // 100 MHz system clock
  input wire logic presetn, // async reset, active low
  // apb slave
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready, always high
  output logic pslverr, // apb error on unmapped address
  // analog comparator results, asynchronous
  input wire logic cmp_sleep, // input below battery plus sleep_offset
  input wire logic cmp_uvlo_ok, // input above lockout level
  input wire logic cmp_ovp, // input above input_overvolt_threshold
  input wire logic cmp_droop, // input at input_droop_threshold
  input wire logic cmp_min_system_voltage, // system at min_system_voltage
  input wire logic cmp_vreg, // battery regulation active
  input wire logic cmp_done, // system at battery plus 3.5 %
  input wire logic cmp_bat_seen, // battery comparator trips
  input wire logic cmp_term_nobat, // termination due to no battery
  input wire logic [9:0] thermistor_sense, // ratio, tenths of percent
  // analog control outputs
  output logic current_mode, // current loop selected
  output logic converter_on, // buck converter running
  output logic bat_switch_on, // battery switch closed
  output logic [12:0] rail_target_mv, // system rail target
  output logic input_limit_cut, // droop reduces input limit
  output logic input_limit_off, // input limit disabled
  output logic [13:0] ovp_level_mv, // selected over-voltage level
  output logic [3:0] vreg_drop, // zone voltage reduction code
  output logic [3:0] ichg_drop, // zone current reduction code
  output logic charge_suspend, // charge stopped by zone
  output logic timer_pause, // safety timer hold
  output logic new_cycle, // one-cycle restart of charge
  output logic status_pulse, // status pin pulse
  output logic int_pulse // interrupt pin pulse
);
  localparam logic [31:0] RAIL_HALF =
    32'(supervisor_pkg::RAIL_HALF_CYC);

  // two-flop synchronisers for all comparator bits
  localparam int NSYNC = 19;
  logic [NSYNC-1:0] raw_in; // unsynchronised bundle
  logic [NSYNC-1:0] meta_q; // first stage, read only by sync_q
  logic [NSYNC-1:0] sync_q; // second stage, safe to use
  assign raw_in = {thermistor_sense, cmp_term_nobat, cmp_bat_seen,
    cmp_done, cmp_vreg, cmp_min_system_voltage, cmp_droop, cmp_ovp,
    cmp_uvlo_ok, cmp_sleep};

  // per-bit synchroniser chain
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= raw_in[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  logic s_sleep, s_uvlo_ok, s_ovp, s_droop, s_min_system_voltage, s_vreg;
  logic s_done, s_bat_seen, s_term_nobat;
  logic [9:0] s_ratio; // synced thermistor ratio
  assign {s_ratio, s_term_nobat, s_bat_seen, s_done, s_vreg,
    s_min_system_voltage, s_droop, s_ovp, s_uvlo_ok, s_sleep} = sync_q;

  // registers
  logic [1:0] ctrl_q; // charge enable, test request
  logic [3:0] ovp_sel_q; // over-voltage code, 500 mV steps
  logic [7:0] warm_prof_q; // warm zone reduction profile
  logic [7:0] cool_prof_q; // cool zone reduction profile
  logic sleep_flt_q, ovp_flt_q; // fault status bits
  logic supply_bad_q; // supply status bit
  logic test_on_q; // test mode active
  logic test_refused_q; // last request refused, sticky

  // apb decode
  logic wr_en, rd_en, hit;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign hit = (paddr == supervisor_pkg::ADDR_CTRL) ||
    (paddr == supervisor_pkg::ADDR_STATUS) ||
    (paddr == supervisor_pkg::ADDR_ZONE) ||
    (paddr == supervisor_pkg::ADDR_OVP);
  assign pready = 1'b1; // zero wait states
  assign pslverr = psel & penable & ~hit;

  // writable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= supervisor_pkg::CTRL_RESET;
      ovp_sel_q <= {1'b0, supervisor_pkg::OVP_RESET};
      warm_prof_q <= supervisor_pkg::WARM_PROFILE_RESET;
      cool_prof_q <= supervisor_pkg::COOL_PROFILE_RESET;
    end else if (wr_en) begin
      case (paddr)
        supervisor_pkg::ADDR_CTRL: ctrl_q <= pwdata[1:0];
        supervisor_pkg::ADDR_ZONE: begin
          warm_prof_q <= pwdata[7:0];
          cool_prof_q <= pwdata[15:8];
        end
        // codes above 8 would pass 10.5V; stored as written, ovp_level_mv clamps them
        supervisor_pkg::ADDR_OVP: ovp_sel_q <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // detection sequencer
  supervisor_pkg::det_state_e det_q;
  logic [31:0] rail_cnt_q; // time left in current rail level
  logic bat_present_q; // sequencer believes a battery exists
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_q <= supervisor_pkg::DET_CHECK;
      rail_cnt_q <= 32'h0;
      bat_present_q <= 1'b0;
    end else begin
      case (det_q)
        supervisor_pkg::DET_CHECK: begin
          // only an absent-battery termination starts the search
          if (s_term_nobat) begin
            det_q <= supervisor_pkg::DET_HIGH;
            rail_cnt_q <= RAIL_HALF;
            bat_present_q <= 1'b0;
          end else begin
            bat_present_q <= 1'b1;
          end
        end
        supervisor_pkg::DET_HIGH, supervisor_pkg::DET_LOW: begin
          if (s_bat_seen) begin
            det_q <= supervisor_pkg::DET_CHECK;
            bat_present_q <= 1'b1;
          end else if (rail_cnt_q <= 32'h1) begin
            rail_cnt_q <= RAIL_HALF;
            det_q <= (det_q == supervisor_pkg::DET_HIGH) ?
              supervisor_pkg::DET_LOW : supervisor_pkg::DET_HIGH;
          end else begin
            rail_cnt_q <= rail_cnt_q - 32'h1;
          end
        end
        default: det_q <= supervisor_pkg::DET_CHECK;
      endcase
    end
  end

  // rail target per detection state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rail_target_mv <= supervisor_pkg::RAIL_HIGH_MV;
    end else if (det_q == supervisor_pkg::DET_LOW) begin
      rail_target_mv <= supervisor_pkg::RAIL_LOW_MV;
    end else begin
      rail_target_mv <= supervisor_pkg::RAIL_HIGH_MV;
    end
  end

  // fault entry and exit
  logic sleep_now, ovp_now, sleep_rise, ovp_rise, any_exit;
  assign sleep_now = s_sleep & s_uvlo_ok;
  assign ovp_now = s_ovp;
  assign sleep_rise = sleep_now & ~sleep_flt_q;
  assign ovp_rise = ovp_now & ~ovp_flt_q;
  assign any_exit = (sleep_flt_q & ~sleep_now) |
    (ovp_flt_q & ~ovp_now);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_flt_q <= 1'b0;
      ovp_flt_q <= 1'b0;
      supply_bad_q <= 1'b0;
      new_cycle <= 1'b0;
    end else begin
      sleep_flt_q <= sleep_now;
      ovp_flt_q <= ovp_now;
      supply_bad_q <= ovp_now;
      new_cycle <= any_exit & ~sleep_now & ~ovp_now;
    end
  end

  // single pulse shared by status and interrupt pins
  logic pulse_w;
  fault_pulse u_pulse (
    .pclk(pclk),
    .presetn(presetn),
    .trig(sleep_rise | ovp_rise),
    .pulse(pulse_w)
  );
  assign status_pulse = pulse_w;
  assign int_pulse = pulse_w;

  // temperature zone classifier
  supervisor_pkg::zone_e zone_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zone_q <= supervisor_pkg::ZONE_NORMAL;
    end else if (s_ratio <= supervisor_pkg::HOT_TRIP) begin
      zone_q <= supervisor_pkg::ZONE_HOT;
    end else if (s_ratio <= supervisor_pkg::WARM_TRIP) begin
      zone_q <= supervisor_pkg::ZONE_WARM;
    end else if (s_ratio >= supervisor_pkg::COLD_TRIP) begin
      zone_q <= supervisor_pkg::ZONE_COLD;
    end else if (s_ratio >= supervisor_pkg::COOL_TRIP) begin
      zone_q <= supervisor_pkg::ZONE_COOL;
    end else begin
      zone_q <= supervisor_pkg::ZONE_NORMAL;
    end
  end

  // zone profile; cold stop is released as soon as the zone leaves cold, with no host action
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vreg_drop <= 4'h0;
      ichg_drop <= 4'h0;
      charge_suspend <= 1'b0;
    end else begin
      case (zone_q)
        supervisor_pkg::ZONE_WARM: begin
          vreg_drop <= warm_prof_q[3:0];
          ichg_drop <= warm_prof_q[7:4];
          charge_suspend <= 1'b0;
        end
        supervisor_pkg::ZONE_COOL: begin
          vreg_drop <= cool_prof_q[3:0];
          ichg_drop <= cool_prof_q[7:4];
          charge_suspend <= 1'b0;
        end
        supervisor_pkg::ZONE_HOT, supervisor_pkg::ZONE_COLD: begin
          vreg_drop <= 4'h0;
          ichg_drop <= 4'h0;
          charge_suspend <= 1'b1;
        end
        default: begin
          vreg_drop <= 4'h0;
          ichg_drop <= 4'h0;
          charge_suspend <= 1'b0;
        end
      endcase
    end
  end

  // production test gate: only with no battery found
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_on_q <= 1'b0;
      test_refused_q <= 1'b0;
    end else if (!ctrl_q[supervisor_pkg::CTRL_TEST_REQ]) begin
      test_on_q <= 1'b0;
      test_refused_q <= 1'b0;
    end else if (!test_on_q) begin
      // battery present, or check still pending: refuse
      if (bat_present_q || det_q == supervisor_pkg::DET_CHECK) begin
        test_refused_q <= 1'b1;
      end else begin
        test_on_q <= 1'b1;
      end
    end
  end

  // analog controls, registered
  logic fault_any;
  assign fault_any = sleep_flt_q | ovp_flt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_mode <= 1'b0;
      converter_on <= 1'b0;
      bat_switch_on <= 1'b0;
      input_limit_cut <= 1'b0;
      input_limit_off <= 1'b0;
      timer_pause <= 1'b0;
      ovp_level_mv <= supervisor_pkg::OVP_MIN_MV;
    end else begin
      current_mode <= s_min_system_voltage | s_vreg | s_done;
      converter_on <= ~fault_any &
        (ctrl_q[supervisor_pkg::CTRL_CHG_EN] | test_on_q);
      bat_switch_on <= fault_any | ~test_on_q;
      input_limit_cut <= s_droop & ~test_on_q;
      input_limit_off <= test_on_q;
      timer_pause <= fault_any | charge_suspend;
      ovp_level_mv <= (ovp_sel_q > 4'h0 &&
        (supervisor_pkg::OVP_MIN_MV + 14'(ovp_sel_q) *
        supervisor_pkg::OVP_STEP_MV) > supervisor_pkg::OVP_MAX_MV) ?
        supervisor_pkg::OVP_MAX_MV :
        14'(supervisor_pkg::OVP_MIN_MV +
        14'(ovp_sel_q) * supervisor_pkg::OVP_STEP_MV);
    end
  end

  // read mux
  always_comb begin
    prdata = 32'h0;
    if (rd_en) begin
      case (paddr)
        supervisor_pkg::ADDR_CTRL: prdata = {30'h0, ctrl_q};
        supervisor_pkg::ADDR_STATUS: prdata = {21'h0, 3'(zone_q),
          3'(det_q), test_refused_q, test_on_q, supply_bad_q,
          ovp_flt_q, sleep_flt_q};
        supervisor_pkg::ADDR_ZONE: prdata = {16'h0, cool_prof_q,
          warm_prof_q};
        supervisor_pkg::ADDR_OVP: prdata = {28'h0, ovp_sel_q};
        default: prdata = 32'h0;
      endcase
    end
  end

  // assertions
  property p_rail;
    @(posedge pclk) disable iff (!presetn)
      det_q == supervisor_pkg::DET_LOW |=>
      rail_target_mv == supervisor_pkg::RAIL_LOW_MV;
  endproperty
  a_rail: assert property (p_rail) else $error("rail low wrong");
  property p_ovp_off;
    @(posedge pclk) disable iff (!presetn)
      ovp_flt_q |=> !converter_on;
  endproperty
  a_ovp_off: assert property (p_ovp_off) else $error("ovp on");
  property p_sleep_pulse;
    @(posedge pclk) disable iff (!presetn)
      sleep_rise && !pulse_w |=> status_pulse && int_pulse;
  endproperty
  a_sleep_pulse: assert property (p_sleep_pulse)
    else $error("no sleep pulse");
  property p_restart;
    @(posedge pclk) disable iff (!presetn)
      $fell(sleep_flt_q) && !ovp_flt_q && !sleep_now && !ovp_now
      |-> new_cycle;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  property p_test_gate;
    @(posedge pclk) disable iff (!presetn)
      $rose(test_on_q) |-> !$past(bat_present_q);
  endproperty
  a_test_gate: assert property (p_test_gate)
    else $error("test with battery");
  property p_test_limit;
    @(posedge pclk) disable iff (!presetn)
      test_on_q |=> input_limit_off && !input_limit_cut;
  endproperty
  a_test_limit: assert property (p_test_limit)
    else $error("limit in test");
  property p_mode;
    @(posedge pclk) disable iff (!presetn)
      s_min_system_voltage |=> current_mode;
  endproperty
  a_mode: assert property (p_mode) else $error("loop wrong");
  property p_pause;
    @(posedge pclk) disable iff (!presetn)
      sleep_flt_q |=> timer_pause;
  endproperty
  a_pause: assert property (p_pause) else $error("no pause");
  property p_stay;
    @(posedge pclk) disable iff (!presetn)
      det_q == supervisor_pkg::DET_HIGH && !s_bat_seen |=>
      det_q != supervisor_pkg::DET_CHECK;
  endproperty
  a_stay: assert property (p_stay) else $error("left search");
  c_search: cover property (@(posedge pclk)
    det_q == supervisor_pkg::DET_LOW);
  c_sleep: cover property (@(posedge pclk) sleep_rise);
  c_test: cover property (@(posedge pclk) $rose(test_on_q));
endmodule

// ===== charger_fault_supervisor_test.sv
// self-checking bench for the charger fault supervisor
`timescale 1ns/1ns
module charger_fault_supervisor_test;
  typedef struct packed {
    logic [9:0] ts; // thermistor ratio
    logic [2:0] loops; // min_system_voltage, vreg, done
    logic [2:0] zone; // expected zone code
    logic susp; // expected suspend
    logic cur; // expected current loop
    logic [7:0] drops; // expected idrop, vdrop; ff skips
  } row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic cmp_sleep, cmp_uvlo_ok, cmp_ovp, cmp_droop, cmp_min_system_voltage;
  logic cmp_vreg, cmp_done, cmp_bat_seen, cmp_term_nobat;
  logic current_mode, converter_on, bat_switch_on, input_limit_cut;
  logic input_limit_off, charge_suspend, timer_pause, new_cycle;
  logic status_pulse, int_pulse, seen;
  logic [9:0] ts;
  logic [12:0] rail_target_mv;
  logic [13:0] ovp_level_mv, vin_mv, vbat_mv;
  logic [3:0] vreg_drop, ichg_drop;
  logic [31:0] exp_ovp;
  int num_errors, checks, len;
  row_s rows [9];

  charger_fault_supervisor dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_sleep(cmp_sleep), .cmp_uvlo_ok(cmp_uvlo_ok),
    .cmp_ovp(cmp_ovp), .cmp_droop(cmp_droop), .cmp_min_system_voltage(cmp_min_system_voltage),
    .cmp_vreg(cmp_vreg), .cmp_done(cmp_done), .cmp_bat_seen(cmp_bat_seen),
    .cmp_term_nobat(cmp_term_nobat), .thermistor_sense(ts),
    .current_mode(current_mode), .converter_on(converter_on),
    .bat_switch_on(bat_switch_on), .rail_target_mv(rail_target_mv),
    .input_limit_cut(input_limit_cut), .input_limit_off(input_limit_off),
    .ovp_level_mv(ovp_level_mv), .vreg_drop(vreg_drop),
    .ichg_drop(ichg_drop), .charge_suspend(charge_suspend),
    .timer_pause(timer_pause), .new_cycle(new_cycle),
    .status_pulse(status_pulse), .int_pulse(int_pulse));
  supply_model model_u (.vin_mv(vin_mv), .vbat_mv(vbat_mv),
    .ovp_level_mv(ovp_level_mv), .cmp_sleep(cmp_sleep),
    .cmp_uvlo_ok(cmp_uvlo_ok), .cmp_ovp(cmp_ovp), .cmp_droop(cmp_droop));

  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // compare and count; case inequality so unknowns never match
  task automatic chk(input logic [31:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // apb transfer: setup, then access held until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1) begin
      chk(32'h0, 32'h1, "apb timeout");
      end_sim();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // waits for the fault pulse and counts it; a bounce drops and
  // re-raises the over-voltage mid-pulse, which must not stretch it
  task automatic pulse_len(input bit bounce);
    int t;
    logic mis;
    t = 0;
    len = 0;
    mis = 1'b0;
    while (status_pulse !== 1'b1 && t < 20) begin
      @(posedge pclk);
      t++;
    end
    while (status_pulse === 1'b1 && len < 30000) begin
      if (int_pulse !== 1'b1) mis = 1'b1;
      if (bounce && len == 100) vin_mv <= 14'h1388;
      if (bounce && len == 300) vin_mv <= 14'h2ee0;
      @(posedge pclk);
      len++;
    end
    chk(mis, 1'b0, "int pulse differs");
  endtask

  // bounded wait for the restart strobe
  task automatic wait_new();
    seen = 1'b0;
    repeat (20) begin
      @(posedge pclk);
      if (new_cycle === 1'b1) seen = 1'b1;
    end
  endtask

  task automatic done_t(input string s);
    $display("test %s done", s);
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    rows = '{'{10'h12c, 3'h0, 3'h1, 1'b1, 1'b0, 8'hff},
             '{10'h12d, 3'h1, 3'h2, 1'b0, 1'b1, 8'h21},
             '{10'h17f, 3'h0, 3'h2, 1'b0, 1'b0, 8'h21},
             '{10'h180, 3'h2, 3'h0, 1'b0, 1'b1, 8'h00},
             '{10'h234, 3'h4, 3'h0, 1'b0, 1'b1, 8'h00},
             '{10'h235, 3'h0, 3'h3, 1'b0, 1'b0, 8'h40},
             '{10'h257, 3'h3, 3'h3, 1'b0, 1'b1, 8'h40},
             '{10'h258, 3'h0, 3'h4, 1'b1, 1'b0, 8'hff},
             '{10'h1c2, 3'h7, 3'h0, 1'b0, 1'b1, 8'h00}};
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {cmp_min_system_voltage, cmp_vreg, cmp_done, cmp_bat_seen, cmp_term_nobat} = '0;
    ts = 10'h1c2;
    vin_mv = 14'h1388; // 5000 mV, healthy supply
    vbat_mv = 14'h0ed8; // 3800 mV
    presetn = 1'b0;
    cyc(3);
    presetn <= 1'b1;
    // zone and loop table
    foreach (rows[i]) begin
      ts <= rows[i].ts;
      {cmp_min_system_voltage, cmp_vreg, cmp_done} <= rows[i].loops;
      cyc(6);
      apb(1'b0, supervisor_pkg::ADDR_STATUS, 32'h0);
      chk(rd[10:8], rows[i].zone, "zone");
      chk(charge_suspend, rows[i].susp, "suspend");
      chk(current_mode, rows[i].cur, "loop select");
      if (rows[i].drops != 8'hff) begin
        chk({ichg_drop, vreg_drop}, rows[i].drops, "drops");
      end
    end
    apb(1'b1, supervisor_pkg::ADDR_CTRL, 32'h0);
    apb(1'b1, supervisor_pkg::ADDR_CTRL, 32'h1);
    done_t("zones");
    // register map, unmapped access and ovp code sweep
    apb(1'b0, supervisor_pkg::ADDR_ZONE, 32'h0);
    chk(rd[15:0], {supervisor_pkg::COOL_PROFILE_RESET,
        supervisor_pkg::WARM_PROFILE_RESET}, "zone reg");
    apb(1'b1, 8'h40, 32'hffffffff);
    chk(err, 1'b1, "unmapped write err");
    apb(1'b0, 8'h40, 32'h0);
    chk({err, rd}, {1'b1, 32'h0}, "unmapped read");
    chk(rail_target_mv, supervisor_pkg::RAIL_HIGH_MV, "rail idle");
    apb(1'b0, supervisor_pkg::ADDR_OVP, 32'h0);
    chk(rd[3:0], supervisor_pkg::OVP_RESET, "ovp reset");
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, supervisor_pkg::ADDR_OVP, 32'(c));
      cyc(3);
      exp_ovp = 32'(supervisor_pkg::OVP_MIN_MV) +
                32'(c) * 32'(supervisor_pkg::OVP_STEP_MV);
      if (exp_ovp > 32'(supervisor_pkg::OVP_MAX_MV)) begin
        exp_ovp = 32'(supervisor_pkg::OVP_MAX_MV);
      end
      chk(ovp_level_mv, exp_ovp, "ovp level");
    end
    done_t("registers");
    // 9000 mV stays under the clamped 10500 mV level of code 15
    vin_mv <= 14'h2328;
    cyc(12);
    chk(status_pulse, 1'b0, "no ovp below level");
    vin_mv <= 14'h2ee0;
    pulse_len(1'b1);
    chk(len, supervisor_pkg::FAULT_PULSE_CYC, "ovp pulse");
    chk({converter_on, bat_switch_on}, 2'h1, "ovp power");
    chk(timer_pause, 1'b1, "ovp pause");
    apb(1'b0, supervisor_pkg::ADDR_STATUS, 32'h0);
    chk(rd[2:1], 2'h3, "ovp bits");
    vin_mv <= 14'h1388;
    wait_new();
    chk(seen, 1'b1, "ovp exit restart");
    apb(1'b0, supervisor_pkg::ADDR_STATUS, 32'h0);
    chk(rd[2:1], 2'h0, "ovp bits clear");
    chk({converter_on, timer_pause}, 2'h2, "ovp resume");
    done_t("overvoltage");
    // below lockout no sleep, then sleep window
    vin_mv <= 14'h07d0;
    cyc(12);
    chk(status_pulse, 1'b0, "no sleep in lockout");
    vin_mv <= 14'h0e74;
    pulse_len(1'b0);
    chk(len, supervisor_pkg::FAULT_PULSE_CYC, "sleep pulse");
    chk({converter_on, bat_switch_on}, 2'h1, "sleep power");
    chk(timer_pause, 1'b1, "sleep pause");
    apb(1'b0, supervisor_pkg::ADDR_STATUS, 32'h0);
    chk(rd[0], 1'b1, "sleep bit");
    vin_mv <= 14'h1388;
    wait_new();
    chk(seen, 1'b1, "sleep exit restart");
    apb(1'b0, supervisor_pkg::ADDR_STATUS, 32'h0);
    chk(rd[0], 1'b0, "sleep bit clear");
    done_t("sleep");
    vin_mv <= 14'h10cc;
    cyc(8);
    chk(input_limit_cut, 1'b1, "droop cut");
    vin_mv <= 14'h1388;
    cyc(8);
    chk(input_limit_cut, 1'b0, "droop gone");
    done_t("droop");
    // test mode refused with a battery, granted while searching
    apb(1'b1, supervisor_pkg::ADDR_CTRL, 32'h3);
    cyc(4);
    apb(1'b0, supervisor_pkg::ADDR_STATUS, 32'h0);
    chk(rd[4:3], 2'h2, "test refused");
    chk(input_limit_off, 1'b0, "limit kept");
    apb(1'b1, supervisor_pkg::ADDR_CTRL, 32'h1);
    cmp_term_nobat <= 1'b1;
    cyc(8);
    apb(1'b0, supervisor_pkg::ADDR_STATUS, 32'h0);
    chk(rd[7:5], supervisor_pkg::DET_HIGH, "search state");
    chk(rail_target_mv, supervisor_pkg::RAIL_HIGH_MV, "rail");
    apb(1'b1, supervisor_pkg::ADDR_CTRL, 32'h3);
    cyc(4);
    apb(1'b0, supervisor_pkg::ADDR_STATUS, 32'h0);
    chk(rd[3], 1'b1, "test on");
    chk(input_limit_off, 1'b1, "limit off");
    apb(1'b1, supervisor_pkg::ADDR_CTRL, 32'h1);
    cmp_term_nobat <= 1'b0;
    cmp_bat_seen <= 1'b1;
    cyc(8);
    apb(1'b0, supervisor_pkg::ADDR_STATUS, 32'h0);
    chk(rd[7:5], supervisor_pkg::DET_CHECK, "battery found");
    done_t("detection");
    // mid-run reset: outputs return to rest, first request right after
    presetn <= 1'b0;
    cyc(2);
    chk({status_pulse, converter_on, bat_switch_on, rail_target_mv,
        ovp_level_mv}, {3'h0, supervisor_pkg::RAIL_HIGH_MV,
        supervisor_pkg::OVP_MIN_MV}, "reset outputs");
    presetn <= 1'b1;
    apb(1'b0, supervisor_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'(supervisor_pkg::CTRL_RESET), "ctrl after reset");
    done_t("reset");
    end_sim();
  end
endmodule

// ===== fault_pulse.sv
// one-shot fault pulse generator of fixed length
`timescale 1ns/1ns
module fault_pulse (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic trig, // single-cycle fault event
  output logic pulse // high for the pulse length
);
  localparam logic [15:0] LEN =
    16'(supervisor_pkg::FAULT_PULSE_CYC);
  logic [15:0] cnt_q; // cycles left in the pulse

  // a trigger while running is ignored so the pulse never stretches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q != 16'h0000) begin
      cnt_q <= cnt_q - 16'h0001;
    end else if (trig) begin
      cnt_q <= LEN;
    end
  end

  assign pulse = (cnt_q != 16'h0000);

  property p_len;
    @(posedge pclk) disable iff (!presetn)
      $rose(pulse) |-> pulse [*8];
  endproperty
  a_len: assert property (p_len)
    else $error("fault pulse too short");
endmodule

// ===== supervisor_pkg.sv
// constants, offsets and types shared by the charger fault supervisor
package supervisor_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned FAULT_PULSE_US = 256;
  localparam int unsigned FAULT_PULSE_CYC = FAULT_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RAIL_PERIOD_MS = 64;
  // half period per detection state, in cycles
  localparam int unsigned RAIL_HALF_CYC =
    RAIL_PERIOD_MS * (CLK_HZ / 1000) / 2;

  // rail targets in millivolts
  localparam logic [12:0] RAIL_HIGH_MV = 13'h1068; // 4200 mV
  localparam logic [12:0] RAIL_LOW_MV = 13'h0e88;  // 3720 mV

  // thermistor trip ratios, in tenths of a percent
  localparam logic [9:0] HOT_TRIP = 10'h12c;   // 30.0 %
  localparam logic [9:0] WARM_TRIP = 10'h17f;  // 38.3 %
  localparam logic [9:0] COOL_TRIP = 10'h235;  // 56.5 %
  localparam logic [9:0] COLD_TRIP = 10'h258;  // 60.0 %

  // over-voltage selection bounds in millivolts (field of register 7)
  localparam logic [13:0] OVP_MIN_MV = 14'h1964; // 6500 mV
  localparam logic [13:0] OVP_MAX_MV = 14'h2904; // 10500 mV
  localparam logic [13:0] OVP_STEP_MV = 14'h01f4; // 500 mV per code
  localparam logic [7:0] OVP_REG_INDEX = 8'h07;

  // apb register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ZONE = 8'h08;
  localparam logic [7:0] ADDR_OVP = 8'h1c; // index 7 times four
  // ctrl field positions
  localparam int unsigned CTRL_CHG_EN = 0;
  localparam int unsigned CTRL_TEST_REQ = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam logic [2:0] OVP_RESET = 3'h3;
  // zone profile field layout: [3:0] voltage drop code, [7:4] current drop
  localparam logic [7:0] WARM_PROFILE_RESET = 8'h21;
  localparam logic [7:0] COOL_PROFILE_RESET = 8'h40;

  // detection sequencer states, one-hot
  typedef enum logic [2:0] {
    DET_CHECK = 3'h1,
    DET_HIGH = 3'h2,
    DET_LOW = 3'h4
  } det_state_e;

  // temperature zones
  typedef enum logic [2:0] {
    ZONE_NORMAL = 3'h0,
    ZONE_HOT = 3'h1,
    ZONE_WARM = 3'h2,
    ZONE_COOL = 3'h3,
    ZONE_COLD = 3'h4
  } zone_e;
endpackage

// ===== supply_model.sv
// analog side model: input supply, battery and their comparators
`timescale 1ns/1ns
module supply_model #(
  parameter int SLEEP_OFFSET_MV = 100, // sleep_offset, plain default
  parameter int SLEEP_HYST_MV = 50, // exit hysteresis, plain default
  parameter int UVLO_MV = 3000, // undervoltage_lockout_level default
  parameter int DROOP_MV = 4360 // input_droop_threshold default
) (
  input wire logic [13:0] vin_mv, // input supply level
  input wire logic [13:0] vbat_mv, // battery level
  input wire logic [13:0] ovp_level_mv, // level chosen by the block
  output logic cmp_sleep, // input below battery plus offset
  output logic cmp_uvlo_ok, // input above lockout level
  output logic cmp_ovp, // input above over-voltage level
  output logic cmp_droop // input sagged to droop level
);
  initial cmp_sleep = 1'b0;
  // sleep comparator holds its state inside the hysteresis band
  always @(vin_mv, vbat_mv) begin
    if (vin_mv < vbat_mv + SLEEP_OFFSET_MV) begin
      cmp_sleep = 1'b1;
    end else if (vin_mv > vbat_mv + SLEEP_OFFSET_MV + SLEEP_HYST_MV) begin
      cmp_sleep = 1'b0;
    end
  end
  // level comparators, no deglitch: the block must sync them itself
  assign cmp_uvlo_ok = vin_mv > UVLO_MV;
  assign cmp_ovp = vin_mv > ovp_level_mv;
  assign cmp_droop = vin_mv <= DROOP_MV;
endmodule
